// File: rtl/asram_host.sv
/*
 asram_host: controller that drives an asynchronous 512K x 16 static memory
 through its pins. Assumes the memory pins are wired directly and that the
 user issues one request at a time on a valid/ready handshake.
*/
// Behaviour
// - write happens only while select, a lane enable and write strobe are all low.
// - controller floats data lines whenever memory may drive them.
// - address held stable for write setup time before write strobe rises.
// - select held low for setup time before write end.
// - each lane enable held low for setup time before write end.
// - wait 5 ms after leaving retention before any access; srst during recovery goes to idle at once, without the wait.
// - during lane-controlled retention select stays at a fixed full level.
// - read needs strobe high, output enable low, select low, a lane low.
`timescale 1ns/1ps
module asram_host
    import asram_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [LANE_W-1:0] req_lanes,
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_rdata,
    input  wire logic              retain_req,
    output logic                   retain_active,
    output logic      [ADDR_W-1:0] mem_addr,
    output logic                   chip_select_n,
    output logic                   low_lane_enable_n,
    output logic                   high_lane_enable_n,
    output logic                   write_strobe_n,
    output logic                   output_enable_n,
    input  wire logic [DATA_W-1:0] mem_data_in,
    output logic      [DATA_W-1:0] mem_data_out,
    output logic                   mem_data_oe
);

    // ***************************
    // state
    // ***************************
    asram_state_e             state;
    asram_state_e             next_state;
    logic         [CNT_W-1:0]  cnt;
    logic         [CNT_W-1:0]  next_cnt;
    logic         [LANE_W-1:0] lanes;
    logic         [LANE_W-1:0] lane_en_n;
    logic         [DATA_W-1:0] lane_mask;
    logic                      cnt_done;
    logic                      take;
    logic                      lanes_ok;
    logic                      rd_capture;

    assign cnt_done = (cnt == '0);
    assign lanes_ok = (req_lanes != '0);
    assign take     = req_valid && req_ready;
    assign req_ready = (state == ASRAM_IDLE) && !retain_req;
    // read data is taken on the last access cycle
    assign rd_capture = (state == ASRAM_READ) && cnt_done;

    // ***************************
    // pin decode
    // ***************************
    // select stays driven high, never floating, in retention
    assign chip_select_n      = !((state == ASRAM_READ) || (state == ASRAM_WRITE));
    // lanes drive only the selected bytes
    assign low_lane_enable_n  = lane_en_n[0];
    assign high_lane_enable_n = lane_en_n[1];
    // strobe falls with select, so memory outputs stay floating
    assign write_strobe_n     = !(state == ASRAM_WRITE);
    // output enable only while reading
    assign output_enable_n    = !(state == ASRAM_READ);
    // drive data only while writing; float during read and turnaround
    assign mem_data_oe        = (state == ASRAM_WRITE);
    assign retain_active      = (state == ASRAM_RETAIN);

    // ***************************
    // per-lane enables and read mask
    // ***************************
    genvar gi;
    generate
        for (gi = 0; gi < LANE_W; gi++)
        begin : g_lane
            // a lane pin falls only with select and its request bit
            assign lane_en_n[gi] = !(!chip_select_n && lanes[gi]);
            // unselected byte reads as zero
            assign lane_mask[gi*(DATA_W/LANE_W) +: (DATA_W/LANE_W)] = {(DATA_W/LANE_W){lanes[gi]}};
        end
    endgenerate

    // ***************************
    // next state
    // ***************************
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        if (!cnt_done)
        begin
            next_cnt = cnt - 1'b1;
        end
        case (state)
            ASRAM_IDLE:
            begin
                if (retain_req)
                begin
                    next_state = ASRAM_RETAIN;
                end
                else if (req_valid && lanes_ok)
                begin
                    next_state = req_write ? ASRAM_WRITE : ASRAM_READ;
                    // hold cycle long enough for access or setup and pulse
                    next_cnt   = req_write ? CNT_W'(WR_CYC - 1) : CNT_W'(RD_CYC - 1);
                end
            end
            ASRAM_READ, ASRAM_WRITE:
            begin
                if (cnt_done)
                begin
                    next_state = ASRAM_TURN;
                    // release time before next access or address change
                    next_cnt   = CNT_W'(((TA_CYC > CYC_MIN) ? TA_CYC : CYC_MIN) - 1);
                end
            end
            ASRAM_TURN:
            begin
                if (cnt_done)
                begin
                    next_state = ASRAM_IDLE;
                end
            end
            ASRAM_RETAIN:
            begin
                if (!retain_req)
                begin
                    next_state = ASRAM_RECOVER;
                    next_cnt   = CNT_W'(REC_CYC - 1);
                end
            end
            ASRAM_RECOVER:
            begin
                if (cnt_done)
                begin
                    next_state = ASRAM_IDLE;
                end
            end
            default:
            begin
                next_state = ASRAM_IDLE;
            end
        endcase
    end

    // ***************************
    // registers
    // ***************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= ASRAM_IDLE;
            cnt   <= '0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // address, data and lanes held through the whole access
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mem_addr     <= '0;
            mem_data_out <= '0;
            lanes        <= '0;
        end
        else if (take && lanes_ok)
        begin
            mem_addr     <= req_addr;
            mem_data_out <= req_wdata;
            lanes        <= req_lanes;
        end
    end

    // capture read data at the end of the access window
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end
        else
        begin
            rsp_valid <= rd_capture;
            if (rd_capture)
            begin
                rsp_rdata <= mem_data_in & lane_mask;
            end
        end
    end

endmodule

// File: inc/asram_pkg.sv
/*
 asram_pkg: constants for the host-side controller of an asynchronous
 512K x 16 static memory. Assumes a 20 MHz clock (50 ns period).
*/
package asram_pkg;

    // ***************************
    // widths
    // ***************************
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned LANE_W = 2;

    // ***************************
    // timing in ns, recovery in ms, slowest grade
    // ***************************
    localparam int unsigned CLK_NS         = 50;
    localparam int unsigned T_ACC_NS       = 85;
    localparam int unsigned T_OE_ACC_NS    = 45;
    localparam int unsigned T_DIS_NS       = 30;
    localparam int unsigned T_WSETUP_NS    = 70;
    localparam int unsigned T_WPULSE_NS    = 60;
    localparam int unsigned T_DSETUP_NS    = 45;
    localparam int unsigned T_CYCLE_NS     = 85;
    localparam int unsigned T_REC_PD_MS    = 5;

    // ***************************
    // derived cycle counts (least times round up)
    // ***************************
    localparam int unsigned RD_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WR_CYC  = (((T_WSETUP_NS > T_WPULSE_NS) ? T_WSETUP_NS : T_WPULSE_NS)
                                       + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TA_CYC  = (T_DIS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CYC_MIN = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned REC_CYC = (T_REC_PD_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W   = 24;

    typedef enum logic [2:0] {
        ASRAM_IDLE,
        ASRAM_RECOVER,
        ASRAM_READ,
        ASRAM_WRITE,
        ASRAM_TURN,
        ASRAM_RETAIN
    } asram_state_e;

endpackage

// File: bench/asram_host_properties.sv
/* asram_host_properties: pin checks of the memory controller.
   Assumes one clock, srst synchronous active high, bound to asram_host. */
`timescale 1ns/1ps
module asram_host_properties
    import asram_pkg::*;
(
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              rsp_valid,
    input wire logic              retain_active,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              chip_select_n,
    input wire logic              low_lane_enable_n,
    input wire logic              high_lane_enable_n,
    input wire logic              write_strobe_n,
    input wire logic              output_enable_n,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic              mem_data_oe
);
    // ***************************
    // properties
    // ***************************
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence wr_start;
        $fell(write_strobe_n);
    endsequence
    sequence rd_start;
        $fell(output_enable_n);
    endsequence
    AST_WR_OVERLAP: assert property (!write_strobe_n |-> !chip_select_n && mem_data_oe
        && !(low_lane_enable_n && high_lane_enable_n)) else $error("write outside select");
    AST_NO_CONTEND: assert property (mem_data_oe |-> output_enable_n) else $error("bus contention");
    AST_ADDR_HOLD: assert property (wr_start |=> !write_strobe_n && $stable(mem_addr)) else $error("addr");
    AST_DATA_HOLD: assert property (wr_start |=> $stable(mem_data_out)) else $error("write data moved");
    AST_CS_SETUP: assert property (wr_start |-> !chip_select_n [*2]) else $error("select setup");
    AST_LANE_SETUP: assert property (wr_start |=> $stable({low_lane_enable_n, high_lane_enable_n}))
        else $error("lane setup");
    AST_RETAIN: assert property (retain_active |-> chip_select_n && low_lane_enable_n
        && high_lane_enable_n) else $error("retention pins");
    AST_READ_ANS: assert property (rd_start |-> ##2 rsp_valid) else $error("read answer");
    AST_TURN: assert property ($rose(chip_select_n) |-> chip_select_n [*3]) else $error("cycle gap");
endmodule
bind asram_host asram_host_properties i_props (.clk(clk), .srst(srst), .rsp_valid(rsp_valid),
    .retain_active(retain_active), .mem_addr(mem_addr), .chip_select_n(chip_select_n),
    .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));

// File: bench/asram_mem_model.sv
/* asram_mem_model: behavioural 512K x 16 static memory.
   Assumes its pins are wired straight to the controller. */
`timescale 1ns/1ps
module asram_mem_model
    import asram_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              cs_n,
    input  wire logic [1:0]        lane_n,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic [DATA_W-1:0] din,
    output logic      [DATA_W-1:0] dout
);
    // ***************************
    // storage and data lines
    // ***************************
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last = 16'h0000;
    wire               sel  = !cs_n && !(&lane_n);
    wire               rd   = sel && we_n && !oe_n;
    always @(posedge clk)
    begin
        last <= ~dout;
        if (sel && !we_n && !lane_n[0])
            mem[addr][7:0] <= din[7:0];
        if (sel && !we_n && !lane_n[1])
            mem[addr][15:8] <= din[15:8];
    end
    // drives only while reading, else shows the inverse of the last value
    assign dout = {(rd && !lane_n[1]) ? mem[addr][15:8] : last[15:8],
                   (rd && !lane_n[0]) ? mem[addr][7:0]  : last[7:0]};
endmodule

// File: bench/asram_host_tb.sv
/* asram_host_tb: self-checking bench of the memory controller.
   Assumes asram_pkg, the memory model and the bound checker. */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; $display("Error %0t: %h not %h", $time, a, e); end end
module asram_host_tb
    import asram_pkg::*;
;
    logic              clk = 0, srst = 1, req_valid = 0, req_write = 0, retain_req = 0;
    logic [ADDR_W-1:0] req_addr = 19'h00000, mem_addr;
    logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, mem_data_in, mem_data_out;
    logic [LANE_W-1:0] req_lanes = 2'h0;
    logic              req_ready, rsp_valid, retain_active, cs_n, ll_n, hl_n, we_n, oe_n, mem_data_oe;
    int                miscompares = 0, checked = 0;
    always #25 clk = ~clk;
    asram_host i_dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retain_req(retain_req),
        .retain_active(retain_active), .mem_addr(mem_addr), .chip_select_n(cs_n),
        .low_lane_enable_n(ll_n), .high_lane_enable_n(hl_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe));
    asram_mem_model i_mem (.clk(clk), .addr(mem_addr), .cs_n(cs_n), .lane_n({hl_n, ll_n}),
        .we_n(we_n), .oe_n(oe_n), .din(mem_data_out), .dout(mem_data_in));
    // ***************************
    // tasks
    // ***************************
    task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [LANE_W-1:0] l);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        req_lanes <= l;
        @(negedge clk);
        while (!req_ready && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 50)
        begin
            miscompares++;
            report_and_stop();
        end
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [LANE_W-1:0] l, output logic [DATA_W-1:0] got);
        int n;
        n = 0;
        req(1'b0, a, 16'h0000, l);
        while (rsp_valid !== 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 10)
        begin
            miscompares++;
            report_and_stop();
        end
        got = rsp_rdata;
    endtask
    task automatic t_write_read();
        logic [DATA_W-1:0] got;
        req(1'b1, 19'h40001, 16'hA55A, 2'h3);
        rd(19'h40001, 2'h3, got);
        `CHK(got, 16'hA55A)
    endtask
    task automatic t_lanes();
        logic [DATA_W-1:0] got;
        req(1'b1, 19'h00005, 16'hFFFF, 2'h3);
        req(1'b1, 19'h00005, 16'h1234, 2'h1);
        rd(19'h00005, 2'h3, got);
        `CHK(got, 16'hFF34)
        rd(19'h00005, 2'h2, got);
        `CHK(got, 16'hFF00)
        req(1'b1, 19'h00005, 16'h0000, 2'h0);
        rd(19'h00005, 2'h3, got);
        `CHK(got, 16'hFF34)
    endtask
    task automatic t_retain();
        @(posedge clk);
        retain_req <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        `CHK(retain_active, 1'b1)
        `CHK(({cs_n, ll_n, hl_n}), 3'h7)
        `CHK(req_ready, 1'b0)
        @(posedge clk);
        retain_req <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        `CHK(retain_active, 1'b0)
        `CHK(req_ready, 1'b0)
    endtask
    task automatic t_reset();
        logic [DATA_W-1:0] got;
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        `CHK(({req_ready, cs_n, we_n, oe_n, mem_data_oe}), 5'h1E)
        rd(19'h00005, 2'h3, got);
        `CHK(got, 16'hFF34)
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_write_read();
        t_lanes();
        t_retain();
        t_reset();
        report_and_stop();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
